/* dv/hostport_properties.sv */
/*
  Concurrent checks on the wires joining the two ends of the host port.
  Assumes tb instantiates it beside the interface; one clock domain.
*/
`timescale 1ns/10ps
module hostport_properties
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic RDWR_STYLE,
  input wire logic port_style_select,
  input wire logic strobe_or_read_n,
  input wire logic direction_select,
  input wire logic chip_select_n,
  input wire logic dev_data_oe_n,
  input wire logic dev_ack_out,
  input wire logic dev_ack_oe_n
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // ==========================================================
  // decode of an open access
  wire rdwr = port_style_select && RDWR_STYLE;
  wire strobe_on = rdwr ? (!strobe_or_read_n || !direction_select)
    : (port_style_select ? strobe_or_read_n : !strobe_or_read_n);
  wire taken = !chip_select_n && strobe_on;
  wire reading = taken && (rdwr ? !strobe_or_read_n : direction_select);
  wire ack_hi = !dev_ack_oe_n && dev_ack_out;
  sequence ack_pulse;
    ack_hi [*2] ##1 dev_ack_oe_n;
  endsequence
  // ack driven low marks the answering cycle; a busy device may still be releasing
  sequence read_held;
    reading && !dev_ack_oe_n && !dev_ack_out;
  endsequence
  // ==========================================================
  // assertions
  ack_float_a: assert property ($rose(ack_hi) |-> ack_pulse)
    else $error("ack high pulse not two cycles then released");
  ack_low_first_a: assert property ($fell(dev_ack_oe_n) |-> !dev_ack_out)
    else $error("ack not driven low first");
  ack_answer_a: assert property ($rose(taken) |-> ##[1:3] !dev_ack_oe_n)
    else $error("access not answered");
  ack_cause_a: assert property ($fell(dev_ack_oe_n) |-> $past(taken))
    else $error("ack driven without an access");
  read_drive_a: assert property (read_held |-> !dev_data_oe_n)
    else $error("read data not driven");
  write_float_a: assert property ((!chip_select_n && !direction_select) [*2] |-> dev_data_oe_n)
    else $error("device drives bus during write");
  select_only_a: assert property (chip_select_n [*3] |-> dev_data_oe_n)
    else $error("device drives bus while deselected");
  reset_float_a: assert property (disable iff (1'b0) !NRST |-> dev_data_oe_n && dev_ack_oe_n)
    else $error("outputs driven in reset");
endmodule : hostport_properties

/* dv/tb.sv */
/*
  Self-checking bench joining host and device ends through the interface.
  Assumes shared pins resolved here; ack has a pull-up.
*/
`timescale 1ns/10ps
module tb;
  import hostport_pkg::*;
  logic core_clk;
  logic nrst;
  logic rdwr_style;
  logic [1:0] style;
  logic req;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ready;
  logic done;
  logic [DATA_W-1:0] rdata;
  logic [SPACE_W-1:0] mss;
  logic [BYTE_W-1:0] float_pat = 8'h00;
  int err_count;
  int n_tests;
  logic [ADDR_W-1:0] addrs [6];
  logic [DATA_W-1:0] datas [6];
  style_type styles [3] = '{STYLE_NONMUX, STYLE_MUX_DS, STYLE_MUX_RDWR};
  hostport_if hostport_if_inst ();
  // ==========================================================
  // pin resolution; a released bus shows a moving pattern, not old data
  wire dev_on = !hostport_if_inst.dev_data_oe_n;
  wire host_on = !hostport_if_inst.host_data_oe_n;
  assign hostport_if_inst.muxed_low_bus = dev_on ? hostport_if_inst.dev_low_out
    : host_on ? hostport_if_inst.host_low_out : float_pat;
  assign hostport_if_inst.upper_data_byte = dev_on ? hostport_if_inst.dev_upper_out
    : host_on ? hostport_if_inst.host_upper_out : ~float_pat;
  assign hostport_if_inst.transfer_ack = hostport_if_inst.dev_ack_oe_n ? 1'b1
    : hostport_if_inst.dev_ack_out;
  always @(posedge core_clk) float_pat <= float_pat + 8'h01;
  hostport_device hostport_device_inst (.CORE_CLK(core_clk), .NRST(nrst),
    .RDWR_STYLE(rdwr_style), .BUS(hostport_if_inst), .MEMORY_SPACE_SELECT(mss));
  hostport_host hostport_host_inst (.CORE_CLK(core_clk), .NRST(nrst), .STYLE(style),
    .REQ(req), .WRITE(write), .ADDR(addr), .WDATA(wdata), .READY(ready), .DONE(done),
    .RDATA(rdata), .BUS(hostport_if_inst));
  hostport_properties hostport_properties_inst (.CORE_CLK(core_clk), .NRST(nrst),
    .RDWR_STYLE(rdwr_style), .port_style_select(hostport_if_inst.port_style_select),
    .strobe_or_read_n(hostport_if_inst.strobe_or_read_n),
    .direction_select(hostport_if_inst.direction_select),
    .chip_select_n(hostport_if_inst.chip_select_n),
    .dev_data_oe_n(hostport_if_inst.dev_data_oe_n), .dev_ack_out(hostport_if_inst.dev_ack_out),
    .dev_ack_oe_n(hostport_if_inst.dev_ack_oe_n));
  // ==========================================================
  // tasks
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [DATA_W-1:0] pick(input int i, input logic [DATA_W-1:0] r);
    return (i == 0) ? 16'hff00 : (i == 5) ? 16'h00ff : r;
  endfunction : pick
  task automatic xfer(input style_type s, input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    int n;
    style = s;
    rdwr_style = (s == STYLE_MUX_RDWR);
    write = wr;
    addr = a;
    wdata = d;
    req = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check({15'h0000, done}, 16'h0001);
  endtask : xfer
  task automatic end_sim();
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    nrst = 1'b0;
    repeat (RESET_MIN_CYC) @(posedge core_clk);
    #1;
    check({14'h0000, mss}, 16'h0000);
    check({14'h0000, dev_on, host_on}, 16'h0000);
    nrst = 1'b1;
  endtask : do_reset
  // ==========================================================
  // stimulus
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
  initial
  begin
    {nrst, rdwr_style, style, req, write, addr, wdata} = '0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(6664));
    do_reset();
    xfer(STYLE_NONMUX, 1'b1, 8'h00, 16'(SPACE_DATA_MEM));
    check({14'h0000, mss}, 16'(SPACE_DATA_MEM));
    for (int k = 0; k < 3; k++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        addrs[i] = 8'(1 + i * 40 + $urandom % 40);
        datas[i] = pick(i, 16'($urandom));
        xfer(styles[k], 1'b1, addrs[i], datas[i]);
      end
      // read back in the next style: address decode must agree across modes
      for (int i = 0; i < 6; i++)
      begin
        xfer(styles[(k + 1) % 3], 1'b0, addrs[i], 16'h0000);
        check(rdata, datas[i]);
      end
    end
    do_reset();
    xfer(STYLE_MUX_RDWR, 1'b1, 8'h00, 16'(SPACE_CONN_MEM));
    check({14'h0000, mss}, 16'(SPACE_CONN_MEM));
    end_sim();
  end
endmodule : tb

/* src/hostport_device.sv */
/*
  Device end of the parallel host port: decodes the three bus styles,
  latches the address in the two mux styles, reads/writes a small internal
  store in three memory spaces and acknowledges each cycle.
  Assumes all pins synchronous to CORE_CLK; host keeps the cycle open
  until the acknowledge shows.
*/
`timescale 1ns/10ps
module hostport_device
  import hostport_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic RDWR_STYLE,
  hostport_if.device BUS,
  output logic [SPACE_W-1:0] MEMORY_SPACE_SELECT
);
  // ==========================================================
  // state
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_END = 2'b11
  } state_type;
  state_type state_q;
  state_type state_d;
  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  logic [DATA_W-1:0] regs_mem [DEPTH];
  logic [DATA_W-1:0] data_mem [DEPTH];
  logic [DATA_W-1:0] conn_mem [DEPTH];
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] rdata_q;
  logic [SPACE_W-1:0] space_q;
  logic [1:0] rel_q;
  logic ack_oe_q;
  // ==========================================================
  // strobe decode
  wire muxed = BUS.port_style_select;
  wire style_rdwr = muxed & RDWR_STYLE;
  wire cs = ~BUS.chip_select_n;
  wire ds_mux = BUS.strobe_or_read_n;
  wire ds_nonmux = ~BUS.strobe_or_read_n;
  wire rd_strb = ~BUS.strobe_or_read_n;
  wire wr_strb = ~BUS.direction_select;
  wire strobe_ds = muxed ? ds_mux : ds_nonmux;
  wire access = cs & (style_rdwr ? (rd_strb | wr_strb) : strobe_ds);
  wire is_read = style_rdwr ? rd_strb : BUS.direction_select;
  // address: latched low bus in mux modes, direct lines otherwise
  wire latch_addr = muxed & BUS.addr_latch_strobe;
  wire [ADDR_W-1:0] cur_addr = muxed ? addr_q : BUS.direct_addr_lines;
  wire [DATA_W-1:0] wdata = {BUS.upper_data_byte, BUS.muxed_low_bus};
  wire start = (state_q == ST_IDLE) & access;
  wire do_write = start & ~is_read;
  wire [SPACE_W-1:0] space_sel = space_q;
  wire ctrl_hit = (space_sel == SPACE_REGS) & (cur_addr == CTRL_ADDR);
  logic [DATA_W-1:0] rd_sel;
  always_comb
  begin
    case (space_sel)
      SPACE_REGS: rd_sel = ctrl_hit ? {14'h0000, space_q} : regs_mem[cur_addr];
      SPACE_DATA_MEM: rd_sel = data_mem[cur_addr];
      SPACE_CONN_MEM: rd_sel = conn_mem[cur_addr];
      default: rd_sel = DATA_RESET;
    endcase
  end
  // ==========================================================
  // cycle sequencing: ack driven low in ST_ACK, the same cycle read data is first driven
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (access) state_d = ST_ACK;
      ST_ACK: if (!access) state_d = ST_END;
      ST_END: if (rel_q == ACK_DRIVE_LAST) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= ST_IDLE;
      addr_q <= ADDR_RESET;
      rdata_q <= DATA_RESET;
      space_q <= SPACE_REGS;
      rel_q <= 2'h0;
      ack_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (latch_addr) addr_q <= BUS.muxed_low_bus;
      if (start) rdata_q <= rd_sel;
      if (do_write && ctrl_hit) space_q <= wdata[SPACE_W-1:0];
      rel_q <= (state_q == ST_END) ? rel_q + 2'h1 : 2'h0;
      ack_oe_q <= (state_d != ST_IDLE);
    end
  end
  // memories hold no reset; only control state is cleared
  always_ff @(posedge CORE_CLK)
  begin
    if (do_write)
    begin
      case (space_sel)
        SPACE_REGS: regs_mem[cur_addr] <= wdata;
        SPACE_DATA_MEM: data_mem[cur_addr] <= wdata;
        SPACE_CONN_MEM: conn_mem[cur_addr] <= wdata;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // pins
  wire drive_data = (state_q == ST_ACK) & is_read & access;
  assign BUS.dev_low_out = rdata_q[BYTE_W-1:0];
  assign BUS.dev_upper_out = rdata_q[DATA_W-1:BYTE_W];
  assign BUS.dev_data_oe_n = ~drive_data;
  // ack low while cycle runs, high in release phase, then floats
  assign BUS.dev_ack_out = (state_q == ST_END);
  assign BUS.dev_ack_oe_n = ~ack_oe_q;
  assign MEMORY_SPACE_SELECT = space_q;
endmodule : hostport_device

/* src/hostport_host.sv */
/*
  Host end of the parallel host port: runs one read or write per request
  in the style chosen by its user and returns read data.
  Assumes the device acknowledges every cycle while select stays low.
*/
`timescale 1ns/10ps
module hostport_host
  import hostport_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [1:0] STYLE,
  input wire logic REQ,
  input wire logic WRITE,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  output logic READY,
  output logic DONE,
  output logic [DATA_W-1:0] RDATA,
  hostport_if.host BUS
);
  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_ALE = 3'b001,
    H_STRB = 3'b011,
    H_DONE = 3'b010
  } hstate_type;
  hstate_type st_q;
  hstate_type st_d;
  logic wr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic done_q;
  logic [1:0] style_q;
  wire muxed = (style_q != STYLE_NONMUX);
  wire rdwr = (style_q == STYLE_MUX_RDWR);
  wire strb = (st_q == H_STRB);
  // ack driven low marks completion; a floating ack reads high through the pull-up
  wire ack_done = strb & ~BUS.transfer_ack;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      H_IDLE: if (REQ) st_d = (STYLE != STYLE_NONMUX) ? H_ALE : H_STRB;
      H_ALE: st_d = H_STRB;
      H_STRB: if (ack_done) st_d = H_DONE;
      H_DONE: st_d = H_IDLE;
      default: st_d = H_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q <= H_IDLE;
      wr_q <= 1'b0;
      addr_q <= ADDR_RESET;
      wdata_q <= DATA_RESET;
      rdata_q <= DATA_RESET;
      done_q <= 1'b0;
      style_q <= STYLE_NONMUX;
    end
    else
    begin
      st_q <= st_d;
      done_q <= (st_q == H_STRB) & ack_done;
      if (st_q == H_IDLE && REQ)
      begin
        wr_q <= WRITE;
        addr_q <= ADDR;
        wdata_q <= WDATA;
        style_q <= STYLE;
      end
      if (ack_done && !wr_q) rdata_q <= {BUS.upper_data_byte, BUS.muxed_low_bus};
    end
  end
  // read data is sampled only on the ack cycle of a read, so the last sample holds
  assign BUS.port_style_select = muxed;
  assign BUS.direct_addr_lines = muxed ? ADDR_RESET : addr_q;
  assign BUS.chip_select_n = ~(st_q == H_ALE | strb);
  assign BUS.addr_latch_strobe = muxed & (st_q == H_ALE);
  assign BUS.strobe_or_read_n = rdwr ? ~(strb & ~wr_q) :
    (muxed ? strb : ~strb);
  assign BUS.direction_select = rdwr ? ~(strb & wr_q) : ~wr_q;
  assign BUS.host_low_out = (st_q == H_ALE) ? addr_q : wdata_q[BYTE_W-1:0];
  assign BUS.host_upper_out = wdata_q[DATA_W-1:BYTE_W];
  assign BUS.host_data_oe_n = ~((st_q == H_ALE) | (strb & wr_q));
  assign READY = (st_q == H_IDLE);
  assign DONE = done_q;
  assign RDATA = rdata_q;
endmodule : hostport_host

/* src/hostport_if.sv */
/*
  Pin-level carrier between the switch host port and its host.
  Two-way pins are split into in/out/oe_n; the testbench resolves wires.
*/
`timescale 1ns/10ps
interface hostport_if;
  import hostport_pkg::*;
  logic port_style_select;
  logic [ADDR_W-1:0] direct_addr_lines;
  logic strobe_or_read_n;
  logic direction_select;
  logic chip_select_n;
  logic addr_latch_strobe;
  // resolved levels of the shared pins
  logic [BYTE_W-1:0] muxed_low_bus;
  logic [BYTE_W-1:0] upper_data_byte;
  logic transfer_ack;
  // device drive
  logic [BYTE_W-1:0] dev_low_out;
  logic [BYTE_W-1:0] dev_upper_out;
  logic dev_data_oe_n;
  logic dev_ack_out;
  logic dev_ack_oe_n;
  // host drive
  logic [BYTE_W-1:0] host_low_out;
  logic [BYTE_W-1:0] host_upper_out;
  logic host_data_oe_n;
  modport device
  (
    input port_style_select, direct_addr_lines, strobe_or_read_n, direction_select,
    input chip_select_n, addr_latch_strobe, muxed_low_bus, upper_data_byte,
    output dev_low_out, dev_upper_out, dev_data_oe_n, dev_ack_out, dev_ack_oe_n
  );
  modport host
  (
    output port_style_select, direct_addr_lines, strobe_or_read_n, direction_select,
    output chip_select_n, addr_latch_strobe, host_low_out, host_upper_out, host_data_oe_n,
    input muxed_low_bus, upper_data_byte, transfer_ack
  );
endinterface : hostport_if

/* src/hostport_pkg.sv */
/*
  Shared constants and types for the parallel host port of a time-slot switch:
  bus widths, port styles, memory spaces, timing counts.
  Assumes a single 250 MHz core clock on both ends.
*/
package hostport_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 8;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 16;
  localparam int SPACE_W = 2;
  // ==========================================================
  // port styles and memory spaces
  typedef enum logic [1:0]
  {
    STYLE_NONMUX = 2'h0,
    STYLE_MUX_DS = 2'h1,
    STYLE_MUX_RDWR = 2'h3
  } style_type;
  typedef enum logic [1:0]
  {
    SPACE_REGS = 2'h0,
    SPACE_DATA_MEM = 2'h1,
    SPACE_CONN_MEM = 2'h2
  } space_type;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACK_DRIVE_CYC = 1;
  localparam logic [1:0] ACK_DRIVE_LAST = 2'(ACK_DRIVE_CYC);
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
endpackage : hostport_pkg
